// File: pkg/ulm_pkg.sv
/*
  constants and types for the upper-part unaligned doubleword load merge.
  assumes one core clock and a 128-bit memory return path.
*/
// Function
// - address is base plus sign-extended 16-bit offset
// - load one to eight upper bytes
// - never cross aligned doubleword boundary
// - addressed byte to byte 7, keep rest
// - bypass previous load result to same target
// - no alignment address exception ever
// - only refill, invalid, address error exceptions
// - send length code and low address bits
// - little-endian: length n mod 8, select half
// - big-endian: length 7 minus n mod 8
// - memory offset per byte order table
// - length code k means k+1 bytes
// - lower-part load fills low bytes, separate
package ulm_pkg;
  localparam int          ULM_OFS_W      = 16;         // displacement width
  localparam logic [3:0]  ULM_LE_HALF_LO = 4'h0;       // le offset, low half
  localparam logic [3:0]  ULM_LE_HALF_HI = 4'h8;       // le offset, high half
  localparam logic [63:0] ULM_RST_DATA   = 64'h0;      // result after reset
  localparam int          ULM_LAT        = 1;          // cycles request to result
  // exception causes reported by translation
  typedef enum logic [1:0] {
    ULM_EXC_NONE    = 2'b00,
    ULM_EXC_REFILL  = 2'b01,
    ULM_EXC_INVALID = 2'b10,
    ULM_EXC_ADDRERR = 2'b11
  } ulm_exc_t;
endpackage

// File: rtl/ulm_merge.sv
/*
  upper-part unaligned doubleword load: address, memory offset and length
  code, and byte merge into the target register.
  the effective address names the most significant byte of an eight-byte
  field that may straddle two aligned doublewords. this unit moves only the
  bytes that share the aligned doubleword of the addressed byte, and so never
  needs more than one doubleword of the returned quadword.
  assumes translation and memory answer combinationally in the request cycle,
  and that the register file read and the bypass data settle in that cycle;
  a separate lower-part load unit handles the companion instruction, and the
  pipeline stalls or flushes around this unit on its own.
*/
`timescale 1ns/10ps
module ulm_merge (
  input  wire logic             mclk,               // core clock
  input  wire logic             rst_n,              // sync reset, low
  input  wire logic             req_valid,          // instruction issued
  input  wire logic [15:0]      offset_imm,         // displacement field
  input  wire logic [31:0]      base_value,         // base register low word
  input  wire logic [4:0]       target_register_field, // target index
  input  wire logic [63:0]      target_old,         // target from register file
  input  wire logic             cpu_byte_order_flag, // 1 = big-endian
  input  wire logic             fwd_valid,          // preceding load result valid
  input  wire logic [4:0]       fwd_reg,            // its target index
  input  wire logic [63:0]      fwd_data,           // its data
  input  wire ulm_pkg::ulm_exc_t xlat_exc,          // translation exception
  input  wire logic [127:0]     mem_quad,           // returned quadword
  output logic [31:0]           virtual_address,    // effective address
  output logic [2:0]            access_length_code, // length code to memory
  output logic [3:0]            mem_offset,         // paddr 3..0 to memory
  output logic                  wb_valid_r,         // write result pulse
  output logic [4:0]            wb_reg_r,           // write target
  output logic [63:0]           wb_data_r,          // merged value
  output logic                  exc_valid_r,        // exception pulse
  output ulm_pkg::ulm_exc_t     exc_code_r          // exception cause
);
  import ulm_pkg::*;

  logic [2:0]  n3;          // n mod 8
  logic        half;        // selected doubleword of quad
  logic [2:0]  byte_sel;    // highest fetched byte index
  logic [63:0] dword;       // fetched aligned doubleword
  logic [63:0] old_val;     // target after bypass
  logic [63:0] merged;      // merged result
  logic [7:0]  load_mask;   // result lanes taken from memory
  logic        bypass_hit;  // pending load writes the same target
  // next values of the registered outputs
  logic        wb_valid_nxt;  // write pulse
  logic [4:0]  wb_reg_nxt;    // write target
  logic [63:0] wb_data_nxt;   // write data
  logic        exc_valid_nxt; // exception pulse
  ulm_exc_t    exc_code_nxt;  // exception cause

  // address, length and offset, all combinational so memory sees them in the
  // request cycle; the adder is the only long path, the rest is a few xors.
  // big-endian flips the byte index within the doubleword and the half
  // select, which is why one merge network serves both byte orders
  always_comb begin
    virtual_address = base_value
      + {{(32-ULM_OFS_W){offset_imm[15]}}, offset_imm};
    n3 = virtual_address[2:0];
    byte_sel = n3 ^ {3{cpu_byte_order_flag}};
    half = virtual_address[3] ^ cpu_byte_order_flag;
    access_length_code = byte_sel;
    // le memory sees only the half base; be memory sees the full low address nibble
    if (cpu_byte_order_flag) begin
      mem_offset = virtual_address[3:0];
    end else begin
      mem_offset = virtual_address[3] ? ULM_LE_HALF_HI : ULM_LE_HALF_LO;
    end
  end

  // merge: bytes byte_sel..0 of the aligned doubleword go to the top
  // lanes of the result, lowest fetched byte lowest; lanes below stay as the
  // register held them. only one doubleword of the quad is ever used, so a
  // field that straddles two doublewords needs the lower-part load as well
  always_comb begin
    dword = half ? mem_quad[127:64] : mem_quad[63:0];
    // bypass avoids needing an idle slot after a load to the same target
    old_val = (fwd_valid && fwd_reg == target_register_field)
      ? fwd_data : target_old;
    // untouched low lanes are what the lower-part load fills in later
    merged = old_val;
    for (int i = 0; i < 8; i++) begin
      if (i <= int'(byte_sel)) begin
        merged[8*(7-int'(byte_sel)+i) +: 8] = dword[8*i +: 8];
      end
    end
  end

  // lane mask and bypass hit, kept apart from the merge so that the checks
  // below describe the lanes a second way rather than reusing the loop
  always_comb begin
    load_mask = 8'h00;
    // lanes from the top down, byte_sel plus one of them
    for (int j = 0; j < 8; j++) begin
      if (j <= int'(byte_sel)) begin
        load_mask[7-j] = 1'h1;
      end
    end
    // same compare as the bypass mux, wanted by the checks on its own
    bypass_hit = fwd_valid && (fwd_reg == target_register_field);
  end

  // next outputs; alignment never faults, only translation does, and the
  // translation answer is taken as it stands in the request cycle
  always_comb begin
    // a fault turns the write into an exception pulse
    exc_valid_nxt = req_valid && (xlat_exc != ULM_EXC_NONE);
    exc_code_nxt  = req_valid ? xlat_exc : ULM_EXC_NONE;
    // the register file only sees a write for a clean access
    wb_valid_nxt  = req_valid && (xlat_exc == ULM_EXC_NONE);
    wb_reg_nxt    = target_register_field;
    wb_data_nxt   = merged;
  end

  // registered outputs; each pulse stands for one cycle, so the register file
  // takes it on the next edge. target and data are registered every cycle,
  // which costs a little power but keeps the enable logic off the wide word
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wb_valid_r  <= 1'b0;
      wb_reg_r    <= 5'h0;
      wb_data_r   <= ULM_RST_DATA;
      exc_valid_r <= 1'b0;
      exc_code_r  <= ULM_EXC_NONE;
    end else begin
      wb_valid_r  <= wb_valid_nxt;
      wb_reg_r    <= wb_reg_nxt;
      wb_data_r   <= wb_data_nxt;
      exc_valid_r <= exc_valid_nxt;
      exc_code_r  <= exc_code_nxt;
    end
  end

  // checks
  // the properties restate the byte tables from lane arithmetic and from the
  // raw quadword rather than from the merge loop, so a slip in the loop bounds
  // or in the half select shows up here; all of them run on the core clock
  // and stay quiet while reset is low

  // request that passed translation, and one that did not
  sequence s_clean_req;
    req_valid && (xlat_exc == ULM_EXC_NONE);
  endsequence
  sequence s_fault_req;
    req_valid && (xlat_exc != ULM_EXC_NONE);
  endsequence
  // no instruction in this cycle
  sequence s_idle;
    !req_valid;
  endsequence
  // clean request on a doubleword boundary: one byte in le order, the whole
  // register in be order
  sequence s_le_corner;
    req_valid && (xlat_exc == ULM_EXC_NONE) && !cpu_byte_order_flag
    && (virtual_address[2:0] == 3'h0);
  endsequence
  sequence s_be_corner;
    req_valid && (xlat_exc == ULM_EXC_NONE) && cpu_byte_order_flag
    && (virtual_address[2:0] == 3'h0);
  endsequence
  // two instructions in adjacent cycles, the second one clean
  sequence s_clean_pair;
    req_valid ##1 (req_valid && (xlat_exc == ULM_EXC_NONE));
  endsequence

  // a write and an exception never share a cycle
  a_wb_no_exc: assert property (@(posedge mclk) disable iff (!rst_n)
    wb_valid_r |-> !exc_valid_r)
    else $error("write with exception");

  // every clean request is answered by a write one edge later
  a_wb_follows_req: assert property (@(posedge mclk) disable iff (!rst_n)
    s_clean_req |=> wb_valid_r)
    else $error("write missing");

  // the addressed byte always lands in the top lane
  a_top_byte: assert property (@(posedge mclk) disable iff (!rst_n)
    s_clean_req |=> wb_data_r[63:56] == $past(dword[8*byte_sel +: 8]))
    else $error("top byte wrong");

  // a one-byte load leaves the seven low lanes as they were
  a_low_kept: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid && byte_sel == 3'h0 |=> wb_data_r[55:0] == $past(old_val[55:0]))
    else $error("low bytes changed");

  // length code in le order is the low three address bits
  a_le_length: assert property (@(posedge mclk) disable iff (!rst_n)
    !cpu_byte_order_flag |-> access_length_code == virtual_address[2:0])
    else $error("le length wrong");

  // length code in be order counts down from seven
  a_be_length: assert property (@(posedge mclk) disable iff (!rst_n)
    cpu_byte_order_flag |-> access_length_code == 3'h7 - virtual_address[2:0])
    else $error("be length wrong");

  // le memory is only told which half of the quad to drive
  a_le_offset: assert property (@(posedge mclk) disable iff (!rst_n)
    !cpu_byte_order_flag |-> mem_offset[2:0] == 3'h0)
    else $error("le offset");

  // an exception pulse always carries a real cause
  a_exc_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
    exc_valid_r |-> exc_code_r != ULM_EXC_NONE)
    else $error("bad cause");

  // with a bypass hit the kept lanes come from the pending load, not the file
  a_bypass: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid && fwd_valid && fwd_reg == target_register_field && byte_sel == 3'h0
    && xlat_exc == ULM_EXC_NONE |=> wb_data_r[55:0] == $past(fwd_data[55:0]))
    else $error("bypass ignored");

  // the address is the base plus the displacement taken as a signed value
  a_va_sum: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid |-> virtual_address == base_value + 32'(signed'(offset_imm)))
    else $error("effective address wrong");

  // a faulted request gives the exception pulse on the next edge, no write
  a_exc_follows_fault: assert property (@(posedge mclk) disable iff (!rst_n)
    s_fault_req |=> exc_valid_r && !wb_valid_r)
    else $error("fault without exception pulse");

  // the cause is handed on unchanged from translation
  a_exc_code_kept: assert property (@(posedge mclk) disable iff (!rst_n)
    s_fault_req |=> exc_code_r == $past(xlat_exc))
    else $error("exception cause changed");

  // nothing is written or raised in the cycle after no instruction
  a_idle_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    s_idle |=> !wb_valid_r && !exc_valid_r)
    else $error("pulse without request");

  // low address bits never raise anything when translation is clean,
  // whatever the alignment of the field
  a_no_align_exc: assert property (@(posedge mclk) disable iff (!rst_n)
    s_clean_req |=> !exc_valid_r)
    else $error("alignment exception raised");

  // the write goes to the register named by the request
  a_wb_target: assert property (@(posedge mclk) disable iff (!rst_n)
    s_clean_req |=> wb_reg_r == $past(target_register_field))
    else $error("write target wrong");

  // be memory gets the full low address nibble
  a_be_offset: assert property (@(posedge mclk) disable iff (!rst_n)
    cpu_byte_order_flag |-> mem_offset == virtual_address[3:0])
    else $error("be offset");

  // le memory offset still follows the half that holds the addressed byte
  a_le_offset_half: assert property (@(posedge mclk) disable iff (!rst_n)
    !cpu_byte_order_flag |-> mem_offset[3] == virtual_address[3])
    else $error("le offset half");

  // the top lane comes from the quad lane chosen by half and byte index,
  // which pins down the doubleword that was used
  a_half_select: assert property (@(posedge mclk) disable iff (!rst_n)
    s_clean_req |=> wb_data_r[63:56]
      == $past(mem_quad[8*{virtual_address[3] ^ cpu_byte_order_flag, byte_sel} +: 8]))
    else $error("wrong doubleword used");

  // lane mask and length code agree: code k moves k+1 lanes
  a_mask_count: assert property (@(posedge mclk) disable iff (!rst_n)
    req_valid |-> $countones(load_mask) == int'(access_length_code) + 1)
    else $error("lane count wrong");

  // a be request at the top of a doubleword replaces the whole register
  a_be_full: assert property (@(posedge mclk) disable iff (!rst_n)
    s_be_corner |=> wb_data_r
      == $past(virtual_address[3] ? mem_quad[63:0] : mem_quad[127:64]))
    else $error("be full load wrong");

  // an le request at the bottom of a doubleword moves one byte only
  a_le_single: assert property (@(posedge mclk) disable iff (!rst_n)
    s_le_corner |=> wb_data_r[63:56] == $past(mem_quad[8*{virtual_address[3], 3'h0} +: 8]))
    else $error("le single byte wrong");

  // without a bypass hit the kept lanes come from the register file
  a_no_bypass: assert property (@(posedge mclk) disable iff (!rst_n)
    s_clean_req ##0 (!bypass_hit && byte_sel == 3'h0)
    |=> wb_data_r[55:0] == $past(target_old[55:0]))
    else $error("stale bypass used");

  // back-to-back instructions are both answered, no idle slot between them
  a_back_to_back: assert property (@(posedge mclk) disable iff (!rst_n)
    s_clean_pair |=> wb_valid_r && ($past(wb_valid_r) || $past(exc_valid_r)))
    else $error("back to back request lost");

  // a fault does not swallow the clean request that follows it
  a_fault_then_clean: assert property (@(posedge mclk) disable iff (!rst_n)
    s_fault_req ##1 s_clean_req |=> wb_valid_r && $past(exc_valid_r))
    else $error("request after fault lost");

  // per lane: a lane outside the mask keeps the old value, a lane inside it
  // takes the fetched byte counted up from the bottom of the doubleword
  for (genvar g = 0; g < 8; g++) begin : g_lane
    a_lane_kept: assert property (@(posedge mclk) disable iff (!rst_n)
      s_clean_req ##0 !load_mask[g]
      |=> wb_data_r[8*g +: 8] == $past(old_val[8*g +: 8]))
      else $error("kept lane changed");
    a_lane_loaded: assert property (@(posedge mclk) disable iff (!rst_n)
      s_clean_req ##0 load_mask[g]
      |=> wb_data_r[8*g +: 8] == $past(dword[8*3'(g + 1 + byte_sel) +: 8]))
      else $error("loaded lane wrong");
  end
endmodule // ulm_merge

// File: sim/ulm_mem_model.sv
/*
  partner: translation and memory path answering in the request cycle.
  assumes the merge unit drives virtual_address combinationally.
*/
`timescale 1ns/10ps
module ulm_mem_model (
  input  wire logic [31:0]       virtual_address, // address from merge unit
  input  wire ulm_pkg::ulm_exc_t fault_sel,       // fault chosen by the bench
  output ulm_pkg::ulm_exc_t      xlat_exc,        // translation answer
  output logic [127:0]           mem_quad         // quadword at the address
);
  import ulm_pkg::*;
  // each lane holds its own index, so a wrong lane or half shows at once
  always_comb begin
    for (int k = 0; k < 16; k++) mem_quad[8*k +: 8] = {virtual_address[7:4], 4'(k)};
  end
  assign xlat_exc = fault_sel; // faults only where the bench asks
endmodule // ulm_mem_model

// File: sim/testbench.sv
/*
  bench for the upper-part load merge: sweeps all 32 offset/order cases,
  then random back-to-back loads with bypass and faults. needs the partner.
*/
`timescale 1ns/10ps
module testbench;
  import ulm_pkg::*;
  logic mclk = 0, rst_n = 0, req_valid = 0, cpu_byte_order_flag = 0, fwd_valid = 0;
  logic [15:0] offset_imm = 0;
  logic [31:0] base_value = 0, virtual_address, va;
  logic [4:0] target_register_field = 0, fwd_reg = 0, wb_reg_r;
  logic [63:0] target_old = 0, fwd_data = 0, wb_data_r, ex;
  logic [127:0] mem_quad;
  logic [2:0] access_length_code, b;
  logic [3:0] mem_offset;
  logic wb_valid_r, exc_valid_r;
  ulm_exc_t xlat_exc, exc_code_r, fault_sel = ULM_EXC_NONE;
  logic [71:0] q[$], e;    // exc, code, reg, data
  int error_cnt = 0, total_checks = 0, seed = 32'hc0a8;
  ulm_merge DUT (.*);
  ulm_mem_model mem (.*);
  initial forever #4 mclk = ~mclk;
  task automatic check(input string what, input logic [63:0] exp, got);
    total_checks++;
    if (exp !== got) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // result watcher: oldest note against each pulse
  always @(posedge mclk) begin
    #2;
    if (wb_valid_r === 1'b1 || exc_valid_r === 1'b1) begin
      e = q.size() ? q.pop_front() : '1;
      check("exc flag", 64'(e[71]), 64'(exc_valid_r));
      if (e[71]) check("exc code", 64'(e[70:69]), 64'(exc_code_r));
      if (e[71]) check("no write", 0, 64'(wb_valid_r));
      else check("wb reg", 64'(e[68:64]), 64'(wb_reg_r));
      if (!e[71]) check("merged", e[63:0], wb_data_r);
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    #1 rst_n = 1;
    for (int i = 0; i < 400; i++) begin
      @(posedge mclk);
      #1 offset_imm = 16'($random(seed));
      base_value = $random(seed);
      target_old = {$random(seed), $random(seed)};
      fwd_data = {$random(seed), $random(seed)};
      va = base_value + {{16{offset_imm[15]}}, offset_imm};
      if (i < 32) base_value = base_value + 32'(4'(i) - va[3:0]);
      va = base_value + {{16{offset_imm[15]}}, offset_imm};
      cpu_byte_order_flag = (i < 32) ? i[4] : seed[3];
      {target_register_field, fwd_valid} = 6'($random(seed));
      fwd_reg = seed[7] ? target_register_field : 5'($random(seed));
      fault_sel = (i % 5 == 3) ? ulm_exc_t'(2'($random(seed))) : ULM_EXC_NONE;
      req_valid = (i < 32) | seed[9];
      b = va[2:0] ^ {3{cpu_byte_order_flag}};
      ex = (fwd_valid && fwd_reg == target_register_field) ? fwd_data : target_old;
      for (int j = 0; j <= b; j++)
        ex[8*(7-j) +: 8] = {va[7:4], 4'({va[3] ^ cpu_byte_order_flag, 3'h0} + b - j)};
      if (req_valid) q.push_back({fault_sel != ULM_EXC_NONE, fault_sel, target_register_field, ex});
      #1 check("address", 64'(va), 64'(virtual_address));
      check("length", 64'(b), 64'(access_length_code));
      check("offset", 64'(cpu_byte_order_flag ? va[3:0] : {va[3], 3'h0}), 64'(mem_offset));
      if (i == 31) $display("order and offset sweep done");
    end
    #1 req_valid = 0;
    repeat (3) @(posedge mclk);
    check("pending results", 0, 64'(q.size()));
    $display("random merge run done");
    wrap_up();
  end
endmodule // testbench
